// ==== design/ccs_regs.sv ====
// Clock, status and debug register bank of the codec
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ccs_regs
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire ccs_pkg::ccs_req_t req,
   input  wire logic              side_driver_short,
   input  wire logic              center_driver_short,
   input  wire logic              synth_locked,
   input  wire logic              synth_powered,
   output logic [15:0]            rdata,
   output logic [4:0]             synth_integer_ratio,
   output logic [10:0]            synth_fraction_ratio,
   output ccs_pkg::ccs_ctl_t      ctl,
   output logic [15:0]            short_ctrl
);
   logic [15:0] synth_ratio_ff;
   logic [15:0] clock_top_ff;
   logic [15:0] debug_one_ff;
   logic [15:0] debug_two_ff;
   logic [15:0] short_ctrl_ff;
   logic [15:0] ana_power_ff;
   logic [15:0] status_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic        retune_pulse_ff;
   ccs_pkg::ccs_ctl_t ctl_ff;
   logic        wr_en;

   assign wr_en = req.wr;

   // register writes; software keeps the ratio stable while running
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         synth_ratio_ff <= ccs_pkg::RST_SYNTH_RATIO;
         clock_top_ff   <= ccs_pkg::RST_CLOCK_TOP;
         debug_one_ff   <= ccs_pkg::RST_DEBUG_ONE;
         debug_two_ff   <= ccs_pkg::RST_DEBUG_TWO;
         short_ctrl_ff  <= ccs_pkg::RST_SHORT_CTRL;
         ana_power_ff   <= ccs_pkg::RST_ANA_POWER;
      end
      else if (wr_en)
      begin
         case (req.addr)
            ccs_pkg::ADDR_SYNTH_RATIO: synth_ratio_ff <= req.wdata;
            ccs_pkg::ADDR_CLOCK_TOP:
               clock_top_ff <= req.wdata & ccs_pkg::MASK_CLOCK_TOP;
            ccs_pkg::ADDR_DEBUG_ONE:   debug_one_ff <= req.wdata;
            ccs_pkg::ADDR_DEBUG_TWO:
               debug_two_ff <= req.wdata & ccs_pkg::MASK_DEBUG_TWO;
            ccs_pkg::ADDR_SHORT_CTRL:
               short_ctrl_ff <= req.wdata & ccs_pkg::MASK_SHORT_CTRL;
            // whole word stored and read back; only the line-out power bit drives a control output
            ccs_pkg::ADDR_ANA_POWER:
               ana_power_ff <= req.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         status_ff <= ccs_pkg::RST_ANA_STATUS;
      else
      begin
         status_ff <= 16'h0000;
         status_ff[ccs_pkg::ST_SIDE_BIT]   <= side_driver_short;
         status_ff[ccs_pkg::ST_CENTER_BIT] <= center_driver_short;
         status_ff[ccs_pkg::ST_LOCK_BIT]   <= synth_locked;
      end
   end

   always_comb
   begin
      nxt_rdata = 16'h0000;
      case (req.addr)
         ccs_pkg::ADDR_SYNTH_RATIO: nxt_rdata = synth_ratio_ff;
         ccs_pkg::ADDR_CLOCK_TOP:   nxt_rdata = clock_top_ff;
         ccs_pkg::ADDR_ANA_STATUS:  nxt_rdata = status_ff;
         ccs_pkg::ADDR_DEBUG_ONE:   nxt_rdata = debug_one_ff;
         ccs_pkg::ADDR_DEBUG_TWO:   nxt_rdata = debug_two_ff;
         ccs_pkg::ADDR_SHORT_CTRL:  nxt_rdata = short_ctrl_ff;
         ccs_pkg::ADDR_ANA_POWER:   nxt_rdata = ana_power_ff;
         default:                   nxt_rdata = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_ff <= 16'h0000;
      else if (req.rd)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= 16'h0000;
   end

   // retune fires on the falling edge of the written bit
   always_ff @(posedge clk)
   begin
      if (srst)
         retune_pulse_ff <= 1'b0;
      else
         retune_pulse_ff <= wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
            && debug_two_ff[ccs_pkg::T2_RETUNE_BIT]
            && !req.wdata[ccs_pkg::T2_RETUNE_BIT];
   end

   // Control outputs registered so the analog side sees clean levels
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // reset levels reach the drivers at once, no class A blip
         ctl_ff                    <= '0;
         ctl_ff.phones_class_ab    <=
            ccs_pkg::RST_DEBUG_ONE[ccs_pkg::T1_CLASS_AB_BIT];
         ctl_ff.center_ground_hold <=
            ccs_pkg::RST_DEBUG_ONE[ccs_pkg::T1_CTR_GND_BIT];
         ctl_ff.phones_ground_hold <=
            ccs_pkg::RST_DEBUG_ONE[ccs_pkg::T1_GND_BIT];
      end
      else
      begin
         // halving only matters with the synthesizer powered
         ctl_ff.synth_halved_in <= clock_top_ff[ccs_pkg::CLK_HALVE_BIT]
            && synth_powered;
         ctl_ff.internal_osc_on <= clock_top_ff[ccs_pkg::INT_OSC_BIT];
         ctl_ff.dac_left_copy <= debug_two_ff[ccs_pkg::T2_COPY_BIT];
         ctl_ff.oscillator_retune <= retune_pulse_ff;
         ctl_ff.phones_class_ab <= debug_one_ff[ccs_pkg::T1_CLASS_AB_BIT];
         ctl_ff.center_ground_hold <= debug_one_ff[ccs_pkg::T1_CTR_GND_BIT];
         ctl_ff.phones_ground_hold <= debug_one_ff[ccs_pkg::T1_GND_BIT];
         ctl_ff.dac_rz_disable <= debug_two_ff[ccs_pkg::T2_RZ_DIS_BIT];
         ctl_ff.adc_dither_disable <= debug_two_ff[ccs_pkg::T2_DITHER_BIT];
         ctl_ff.adc_edge_invert <= debug_two_ff[ccs_pkg::T2_ADC_EDGE_BIT];
         ctl_ff.dac_edge_invert <= debug_two_ff[ccs_pkg::T2_DAC_EDGE_BIT];
         ctl_ff.mic_loop_test_path <=
            debug_one_ff[ccs_pkg::T1_MIC_LOOP_BIT];
         ctl_ff.lineout_power <= ana_power_ff[ccs_pkg::PWR_LINEOUT_BIT];
      end
   end

   assign rdata                = rdata_ff;
   assign synth_integer_ratio  = synth_ratio_ff[15:ccs_pkg::INT_RATIO_LSB];
   assign synth_fraction_ratio = synth_ratio_ff[10:0];
   assign ctl                  = ctl_ff;
   assign short_ctrl           = short_ctrl_ff;

   a_status_lock: assert property (@(posedge clk) disable iff (srst)
      req.rd && req.addr == ccs_pkg::ADDR_ANA_STATUS ##1 !$past(srst, 2)
      |-> rdata[ccs_pkg::ST_LOCK_BIT] == $past(synth_locked, 2))
      else $error("lock flag read mismatch");

   a_status_side: assert property (@(posedge clk) disable iff (srst)
      req.rd && req.addr == ccs_pkg::ADDR_ANA_STATUS ##1 !$past(srst, 2)
      |-> rdata[ccs_pkg::ST_SIDE_BIT] == $past(side_driver_short, 2))
      else $error("side short read mismatch");

   a_status_center: assert property (@(posedge clk) disable iff (srst)
      req.rd && req.addr == ccs_pkg::ADDR_ANA_STATUS ##1 !$past(srst, 2)
      |-> rdata[ccs_pkg::ST_CENTER_BIT]
         == $past(center_driver_short, 2))
      else $error("center short read mismatch");

   a_int_ratio_wr: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_SYNTH_RATIO
      |=> synth_integer_ratio == $past(req.wdata[15:11]))
      else $error("integer ratio not stored");

   a_ratio_reset: assert property (@(posedge clk)
      srst |=> synth_integer_ratio == ccs_pkg::RST_SYNTH_RATIO[15:11]
      && synth_fraction_ratio == ccs_pkg::RST_SYNTH_RATIO[10:0])
      else $error("ratio reset value wrong");

   a_halve_pass: assert property (@(posedge clk) disable iff (srst)
      synth_powered && clock_top_ff[ccs_pkg::CLK_HALVE_BIT]
      |=> ctl.synth_halved_in)
      else $error("halving not applied");

   // clear bit passes the clock through
   a_halve_clear: assert property (@(posedge clk) disable iff (srst)
      !clock_top_ff[ccs_pkg::CLK_HALVE_BIT] |=> !ctl.synth_halved_in)
      else $error("halving active with bit clear");

   // no halving while the synthesizer is down
   a_halve_gate: assert property (@(posedge clk) disable iff (srst)
      !synth_powered |=> !ctl.synth_halved_in)
      else $error("halving active while synth down");

   // one retune pulse after the bit falls
   a_retune_fall: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      && debug_two_ff[ccs_pkg::T2_RETUNE_BIT]
      && !req.wdata[ccs_pkg::T2_RETUNE_BIT]
      |-> ##2 ctl.oscillator_retune ##1 !ctl.oscillator_retune)
      else $error("retune pulse missing");

   // no retune unless the bit was high
   a_retune_quiet: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      && !debug_two_ff[ccs_pkg::T2_RETUNE_BIT]
      |-> ##2 !ctl.oscillator_retune)
      else $error("retune pulse without a falling bit");

   a_copy_follow: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      |-> ##2 ctl.dac_left_copy
         == $past(req.wdata[ccs_pkg::T2_COPY_BIT], 2))
      else $error("mono copy not applied");

   a_rz_follow: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      |-> ##2 ctl.dac_rz_disable
         == $past(req.wdata[ccs_pkg::T2_RZ_DIS_BIT], 2))
      else $error("return-to-zero control not applied");

   a_dither_follow: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      |-> ##2 ctl.adc_dither_disable
         == $past(req.wdata[ccs_pkg::T2_DITHER_BIT], 2))
      else $error("dither control not applied");

   // input converter edge follows the write
   a_adc_edge: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      |-> ##2 ctl.adc_edge_invert
         == $past(req.wdata[ccs_pkg::T2_ADC_EDGE_BIT], 2))
      else $error("input converter edge not applied");

   // output converter edge follows the write
   a_dac_edge: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_TWO
      |-> ##2 ctl.dac_edge_invert
         == $past(req.wdata[ccs_pkg::T2_DAC_EDGE_BIT], 2))
      else $error("output converter edge not applied");

   a_ab_select: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_ONE
      |-> ##2 ctl.phones_class_ab
         == $past(req.wdata[ccs_pkg::T1_CLASS_AB_BIT], 2))
      else $error("amplifier class not applied");

   // center ground hold follows the write
   a_center_hold: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_ONE
      |-> ##2 ctl.center_ground_hold
         == $past(req.wdata[ccs_pkg::T1_CTR_GND_BIT], 2))
      else $error("center ground hold not applied");

   // headphone ground hold follows the write
   a_phones_hold: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_ONE
      |-> ##2 ctl.phones_ground_hold
         == $past(req.wdata[ccs_pkg::T1_GND_BIT], 2))
      else $error("headphone ground hold not applied");

   // mic test path follows the write
   a_mic_path: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_DEBUG_ONE
      |-> ##2 ctl.mic_loop_test_path
         == $past(req.wdata[ccs_pkg::T1_MIC_LOOP_BIT], 2))
      else $error("mic test path not applied");

   a_lineout_pwr: assert property (@(posedge clk) disable iff (srst)
      wr_en && req.addr == ccs_pkg::ADDR_ANA_POWER
      |-> ##2 ctl.lineout_power
         == $past(req.wdata[ccs_pkg::PWR_LINEOUT_BIT], 2))
      else $error("line-out power not applied");

   // reset levels still driven after release
   a_class_ab: assert property (@(posedge clk)
      $fell(srst) |-> ##1 ctl.phones_class_ab && ctl.phones_ground_hold
      && ctl.center_ground_hold)
      else $error("debug one reset bits wrong");

   // drivers hold their reset levels during reset
   a_reset_holds: assert property (@(posedge clk)
      srst |=> ctl.phones_class_ab && ctl.center_ground_hold
      && ctl.phones_ground_hold && !ctl.lineout_power)
      else $error("reset levels not driven");

   // Read data stands only in the cycle after a read strobe
   a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
      !req.rd |=> rdata == 16'h0000)
      else $error("read data outside the read cycle");

   // Main scenarios the bench is expected to reach
   c_status_read: cover property (@(posedge clk)
      req.rd && req.addr == ccs_pkg::ADDR_ANA_STATUS ##1 rdata != 16'h0000);
   c_retune: cover property (@(posedge clk) ctl.oscillator_retune);
   c_halved: cover property (@(posedge clk) ctl.synth_halved_in);
   c_mono_copy: cover property (@(posedge clk) ctl.dac_left_copy);
   c_lineout_on: cover property (@(posedge clk) ctl.lineout_power);
endmodule : ccs_regs
`default_nettype wire

// ==== pkg/ccs_pkg.sv ====
// Package: register map, field positions and reset values of the clock/status bank
package ccs_pkg;
   localparam logic [7:0]  ADDR_SYNTH_RATIO = 8'h32;
   localparam logic [7:0]  ADDR_CLOCK_TOP   = 8'h34;
   localparam logic [7:0]  ADDR_ANA_STATUS  = 8'h36;
   localparam logic [7:0]  ADDR_DEBUG_ONE   = 8'h38;
   localparam logic [7:0]  ADDR_DEBUG_TWO   = 8'h3a;
   localparam logic [7:0]  ADDR_SHORT_CTRL  = 8'h3c;
   localparam logic [7:0]  ADDR_ANA_POWER   = 8'h30;

   localparam int INT_RATIO_LSB   = 11;
   localparam int CLK_HALVE_BIT   = 3;
   localparam int INT_OSC_BIT     = 11;
   localparam int ST_SIDE_BIT     = 9;
   localparam int ST_CENTER_BIT   = 8;
   localparam int ST_LOCK_BIT     = 4;
   localparam int T1_CLASS_AB_BIT = 8;
   localparam int T1_CTR_GND_BIT  = 7;
   localparam int T1_GND_BIT      = 6;
   localparam int T1_MIC_LOOP_BIT = 1;
   localparam int T2_COPY_BIT     = 12;
   localparam int T2_RETUNE_BIT   = 11;
   localparam int T2_DAC_EDGE_BIT = 9;
   localparam int T2_RZ_DIS_BIT   = 5;
   localparam int T2_ADC_EDGE_BIT = 3;
   localparam int T2_DITHER_BIT   = 0;
   localparam int PWR_LINEOUT_BIT = 0;
   localparam int PWR_SYNTH_BIT   = 10;

   localparam logic [15:0] RST_SYNTH_RATIO = 16'h5000;
   localparam logic [15:0] RST_CLOCK_TOP   = 16'h0000;
   localparam logic [15:0] RST_ANA_STATUS  = 16'h0000;
   localparam logic [15:0] RST_DEBUG_ONE   = 16'h01c0;
   localparam logic [15:0] RST_DEBUG_TWO   = 16'h0000;
   localparam logic [15:0] RST_SHORT_CTRL  = 16'h0000;
   localparam logic [15:0] RST_ANA_POWER   = 16'h0000;
   localparam logic [15:0] MASK_CLOCK_TOP  = 16'h0fff;
   localparam logic [15:0] MASK_DEBUG_TWO  = 16'h7fff;
   localparam logic [15:0] MASK_SHORT_CTRL = 16'h777f;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } ccs_req_t;

   typedef struct packed {
      logic       synth_halved_in;
      logic       dac_left_copy;
      logic       oscillator_retune;
      logic       phones_class_ab;
      logic       center_ground_hold;
      logic       phones_ground_hold;
      logic       dac_rz_disable;
      logic       adc_dither_disable;
      logic       adc_edge_invert;
      logic       dac_edge_invert;
      logic       mic_loop_test_path;
      logic       lineout_power;
      logic       internal_osc_on;
   } ccs_ctl_t;
endpackage : ccs_pkg

// ==== tb/tb_top.sv ====
// Self-checking bench for the clock, status and debug register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   ccs_pkg::ccs_req_t req = '0;
   logic              side_s = 1'b0;
   logic              cen_s = 1'b0;
   logic              lock = 1'b0;
   logic              pwr = 1'b0;
   logic [15:0]       rdata;
   logic [4:0]        iratio;
   logic [10:0]       fratio;
   ccs_pkg::ccs_ctl_t ctl;
   logic [15:0]       sctl;
   logic [15:0]       rv;
   int                fail_count = 0;
   int                cmp_count = 0;
   int                cycles = 0;
   int                pulses;
   int                bit_pos [5] = '{12, 5, 0, 3, 9};

   always #4 clk = ~clk;

   ccs_regs DUT
   (
      .clk                 (clk),
      .srst                (srst),
      .req                 (req),
      .side_driver_short   (side_s),
      .center_driver_short (cen_s),
      .synth_locked        (lock),
      .synth_powered       (pwr),
      .rdata               (rdata),
      .synth_integer_ratio (iratio),
      .synth_fraction_ratio(fratio),
      .ctl                 (ctl),
      .short_ctrl          (sctl)
   );

   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   // Control outputs lag the write by two cycles
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic set_in(input logic [3:0] v);
      @(posedge clk);
      {side_s, cen_s, lock, pwr} <= v;
   endtask : set_in

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fail_count++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      settle();
      rd_chk(ccs_pkg::ADDR_SYNTH_RATIO, 16'h5000);
      chk({11'h000, iratio}, 16'h000a);
      rd_chk(ccs_pkg::ADDR_DEBUG_ONE, 16'h01c0);
      chk({13'h0, ctl.phones_class_ab, ctl.center_ground_hold,
           ctl.phones_ground_hold}, 16'h0007);
      rd_chk(ccs_pkg::ADDR_DEBUG_TWO, 16'h0000);
      rd_chk(ccs_pkg::ADDR_ANA_POWER, 16'h0000);
      $display("test reset done");
      // 24 MHz reference halved to 12 MHz, 48 kHz family: 196.608 / 12
      wr(ccs_pkg::ADDR_SYNTH_RATIO, 16'h8312);
      settle();
      rd_chk(ccs_pkg::ADDR_SYNTH_RATIO, 16'h8312);
      chk({11'h000, iratio}, 16'h0010);
      chk({5'h00, fratio}, 16'h0312);
      $display("test ratio done");
      wr(ccs_pkg::ADDR_CLOCK_TOP, 16'hffff);
      settle();
      rd_chk(ccs_pkg::ADDR_CLOCK_TOP, 16'h0fff);
      chk({14'h0, ctl.synth_halved_in, ctl.internal_osc_on}, 16'h1);
      set_in(4'b0001);
      settle();
      chk({15'h0, ctl.synth_halved_in}, 16'h0001);
      wr(ccs_pkg::ADDR_CLOCK_TOP, 16'h0800);
      settle();
      chk({14'h0, ctl.synth_halved_in, ctl.internal_osc_on}, 16'h1);
      $display("test clock done");
      for (int i = 0; i < 8; i++)
      begin
         set_in({i[2:0], 1'b1});
         settle();
         rd_chk(ccs_pkg::ADDR_ANA_STATUS,
                {6'h0, i[2], i[1], 3'h0, i[0], 4'h0});
      end
      // Status is read-only: a write must leave the live view alone
      wr(ccs_pkg::ADDR_ANA_STATUS, 16'hffff);
      set_in(4'b0000);
      settle();
      rd_chk(ccs_pkg::ADDR_ANA_STATUS, 16'h0000);
      $display("test status done");
      for (int i = 0; i < 5; i++)
      begin
         wr(ccs_pkg::ADDR_DEBUG_TWO, 16'h0001 << bit_pos[i]);
         settle();
         chk({11'h0, ctl.dac_left_copy, ctl.dac_rz_disable,
              ctl.adc_dither_disable, ctl.adc_edge_invert,
              ctl.dac_edge_invert}, 16'h0010 >> i);
      end
      wr(ccs_pkg::ADDR_DEBUG_TWO, 16'hffff);
      settle();
      rd_chk(ccs_pkg::ADDR_DEBUG_TWO, 16'h7fff);
      pulses = 0;
      wr(ccs_pkg::ADDR_DEBUG_TWO, 16'h0000);
      repeat (6)
      begin
         @(posedge clk);
         #1;
         if (ctl.oscillator_retune === 1'b1)
            pulses++;
      end
      chk(pulses[15:0], 16'h0001);
      $display("test debug two done");
      wr(ccs_pkg::ADDR_DEBUG_ONE, 16'h0002);
      settle();
      chk({12'h0, ctl.phones_class_ab, ctl.center_ground_hold,
           ctl.phones_ground_hold, ctl.mic_loop_test_path}, 16'h1);
      wr(ccs_pkg::ADDR_ANA_POWER, 16'h0001);
      settle();
      chk({15'h0, ctl.lineout_power}, 16'h0001);
      $display("test debug one and power done");
      wr(ccs_pkg::ADDR_SHORT_CTRL, 16'hffff);
      wr(8'h40, 16'hffff);
      settle();
      rd_chk(ccs_pkg::ADDR_SHORT_CTRL, 16'h777f);
      chk(sctl, 16'h777f);
      rd_chk(8'h40, 16'h0000);
      rd_chk(8'h3e, 16'h0000);
      $display("test short control and unmapped done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
